/* File: hw/gtt_pkg.sv */
/*
 * Shared constants and carrier types for the guest translation tag control.
 * Assumes the core pipeline delivers mode, control and access fields
 * synchronous to core_clk_in.
 */
package gtt_pkg;

	// ----------------------------------------------------------------
	// Widths and field positions
	// ----------------------------------------------------------------
	localparam int TAG_W          = 16;
	localparam int PCT_W          = 12;
	localparam int GPA_W          = 48;
	localparam int PTR_HI         = 51;
	localparam int PTR_LO         = 12;
	localparam int PTR_W          = PTR_HI - PTR_LO + 1;
	localparam int LIN_DIR_HI     = 31;
	localparam int LIN_DIR_LO     = 22;
	localparam int LIN_TBL_HI     = 21;
	localparam int LIN_TBL_LO     = 12;
	localparam int LIN_OFF_HI     = 11;
	localparam int TOP_IDX_HI     = 47;
	localparam int TOP_IDX_LO     = 39;
	localparam int ENTRY_ADR_W    = 52;
	localparam int PRIMARY_GATE   = 31;
	localparam int PAGE_SIZE_BIT  = 7;
	localparam int PTE_COUNT      = 4;
	localparam int WALK_MAX       = 4;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [TAG_W-1:0] TAG_ROOT  = 16'h0000;
	localparam logic [1:0]       PTR_IDX_RST = 2'h0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		GTT_OUTSIDE = 2'h0,
		GTT_ROOT    = 2'h1,
		GTT_GUEST   = 2'h3
	} gtt_mode_t;

	typedef struct packed {
		gtt_mode_t         mode;
		logic              tag_enable;
		logic [TAG_W-1:0]  tag_field;
		logic [31:0]       primary_ctls;
		logic              sl_enable;
		logic [63:0]       sl_root_pointer;
	} gtt_ctl_t;

	typedef struct packed {
		logic paging_enable_flag;
		logic address_extension_flag;
		logic long_mode_active_flag;
	} gtt_flags_t;

	typedef struct packed {
		logic             valid;
		logic [TAG_W-1:0] vtag;
		logic [PCT_W-1:0] pctag;
	} gtt_entry_tag_t;

	typedef struct packed {
		logic [2:0] allowed;
		logic [2:0] wanted;
	} gtt_perm_t;

endpackage

/* File: hw/gtt_tag_match.sv */
/*
 * Tag comparator for one cached translation entry.
 * Assumes current tags are already resolved by the caller.
 */
`timescale 1ns/1ps
module gtt_tag_match #(
	parameter int TAG_W = gtt_pkg::TAG_W,
	parameter int PCT_W = gtt_pkg::PCT_W
) (
	input  wire logic             valid_in,
	input  wire logic [TAG_W-1:0] entry_vtag_in,
	input  wire logic [PCT_W-1:0] entry_pctag_in,
	input  wire logic [TAG_W-1:0] cur_vtag_in,
	input  wire logic [PCT_W-1:0] cur_pctag_in,
	input  wire logic             pct_on_in,
	output logic                  hit_out
);
	// ----------------------------------------------------------------
	// Match
	// ----------------------------------------------------------------
	// Process tag ignored when not in use; both must match otherwise
	always_comb begin
		hit_out = valid_in && (entry_vtag_in == cur_vtag_in) && // R4
			(!pct_on_in || entry_pctag_in == cur_pctag_in);  // R4
	end
endmodule

/* File: hw/gtt_core.sv */
/*
 * Guest translation tag control: current tag selection, tagged lookup,
 * guest-physical identification and second-level translation requests.
 * Assumes a separate walker services sl_req and returns permissions.
 */
`timescale 1ns/1ps
// Overview of operation
// R1 - Translation tags are sixteen bits wide
// R2 - Tag zero outside, in root, or disabled
// R3 - Guest with enable uses structure tag field
// R4 - Entry hits only when both tags match
// R5 - Mode switches keep cache; tag changes space
// R6 - Second-level translation active only when enabled
// R7 - Primary bit 31 clear forces disable
// R8 - Paging off: linear address is guest-physical
// R9 - Root, structure, pointer, leaf addresses guest-physical
// R10 - Two-level walk: 31:22, 21:12, 11:0 fields
// R11 - Disallowed access raises violation and exit
// R12 - Translate only on real memory use
// R13 - Non-extension root load does not translate
// R14 - Extension root load fetches four entries, translates
// R15 - Extension paging: paging, extension, not long
// R16 - Other control writes reloading entries translate
// R17 - Pointer entries translated on use, not load
// R18 - Use bits 47:0, at most four reads
// R19 - Top entry address from pointer and 47:39
module gtt_core #(
	parameter int ENTRIES = 4
) (
	input  wire logic                  core_clk_in,
	input  wire logic                  rst_in,
	input  wire gtt_pkg::gtt_ctl_t     ctl_in,
	input  wire gtt_pkg::gtt_flags_t   flags_in,
	input  wire logic [gtt_pkg::PCT_W-1:0] pctag_in,
	input  wire logic                  pct_on_in,
	input  wire gtt_pkg::gtt_entry_tag_t [ENTRIES-1:0] entries_in,
	input  wire logic                  root_load_in,
	input  wire logic [31:0]           root_value_in,
	input  wire logic                  ctl_reload_in,
	input  wire logic                  mem_access_in,
	input  wire logic [31:0]           lin_addr_in,
	input  wire logic [1:0]            walk_level_in,
	input  wire logic [31:0]           entry_frame_in,
	input  wire logic                  leaf_size_in,
	input  wire logic                  sl_done_in,
	input  wire gtt_pkg::gtt_perm_t    perm_in,
	input  wire logic                  mode_switch_in,
	output logic [gtt_pkg::TAG_W-1:0]  cur_tag_out,
	output logic [ENTRIES-1:0]         hit_out,
	output logic                       sl_active_out,
	output logic                       ext_paging_out,
	output logic                       sl_req_out,
	output logic [gtt_pkg::GPA_W-1:0]  sl_gpa_out,
	output logic [gtt_pkg::ENTRY_ADR_W-1:0] sl_top_entry_out,
	output logic                       pte_fetch_out,
	output logic [1:0]                 pte_idx_out,
	output logic                       violation_out,
	output logic                       guest_exit_out,
	output logic                       flush_out
);
	// ----------------------------------------------------------------
	// Parameter checks
	// ----------------------------------------------------------------
	// Index and pad widths below are fixed by these package values
	if (ENTRIES < 1 || ENTRIES > 64) begin : g_bad_entries
		$error("ENTRIES out of range");
	end
	if (gtt_pkg::PTE_COUNT != 4) begin : g_bad_pte_count
		$error("PTE_COUNT does not fit the two-bit entry index");
	end
	if (gtt_pkg::GPA_W <= 32 || gtt_pkg::TAG_W != 16) begin : g_bad_widths
		$error("GPA_W or TAG_W not served by this logic");
	end

	// ----------------------------------------------------------------
	// Tag selection and matching
	// ----------------------------------------------------------------
	// Registered so a lookup never sees a half-switched tag
	logic [gtt_pkg::TAG_W-1:0] tag_d; // R1
	logic [gtt_pkg::TAG_W-1:0] tag_q;
	always_comb begin
		tag_d = gtt_pkg::TAG_ROOT; // R2
		if (ctl_in.mode == gtt_pkg::GTT_GUEST && ctl_in.tag_enable)
			tag_d = ctl_in.tag_field; // R3
	end
	always_ff @(posedge core_clk_in) begin
		if (rst_in)
			tag_q <= gtt_pkg::TAG_ROOT;
		else
			tag_q <= tag_d;
	end
	assign cur_tag_out = tag_q;

	genvar gi;
	generate
		for (gi = 0; gi < ENTRIES; gi++) begin : g_match
			gtt_tag_match u_match (
				.valid_in       (entries_in[gi].valid),
				.entry_vtag_in  (entries_in[gi].vtag),
				.entry_pctag_in (entries_in[gi].pctag),
				.cur_vtag_in    (tag_q),
				.cur_pctag_in   (pctag_in),
				.pct_on_in      (pct_on_in),
				.hit_out        (hit_out[gi])
			);
		end
	endgenerate

	// Tagged entries survive switches; only untagged use must flush
	logic flush_d;
	logic flush_q;
	always_comb begin
		flush_d = mode_switch_in && !ctl_in.tag_enable; // R5
	end
	always_ff @(posedge core_clk_in) begin
		if (rst_in)
			flush_q <= 1'b0;
		else
			flush_q <= flush_d;
	end
	assign flush_out = flush_q;

	// ----------------------------------------------------------------
	// Enable gating and paging mode
	// ----------------------------------------------------------------
	// Root-side addresses are already physical, so guest mode gates too
	logic sl_on;
	logic ext_on;
	always_comb begin
		sl_on = ctl_in.sl_enable && // R6
			ctl_in.primary_ctls[gtt_pkg::PRIMARY_GATE] && // R7
			ctl_in.mode == gtt_pkg::GTT_GUEST; // R6
		ext_on = flags_in.paging_enable_flag &&
			flags_in.address_extension_flag &&
			!flags_in.long_mode_active_flag; // R15
	end
	assign sl_active_out  = sl_on;
	assign ext_paging_out = ext_on;

	// ----------------------------------------------------------------
	// Guest-physical address selection
	// ----------------------------------------------------------------
	logic [31:0]               root_q;
	logic [31:0]               root_d;
	logic [31:0]               gpa_lo;
	logic [gtt_pkg::GPA_W-1:0] gpa;
	logic                      gpa_use;

	// Entries are four bytes wide, so each index lands on a word
	logic [31:0] dir_term;
	logic [31:0] tbl_term;
	logic [31:0] page_term;
	logic [31:0] large_term;
	logic [31:0] leaf_term;
	assign dir_term = {root_q[31:gtt_pkg::LIN_TBL_LO],
		lin_addr_in[gtt_pkg::LIN_DIR_HI:gtt_pkg::LIN_DIR_LO],
		2'h0}; // R10
	assign tbl_term = {entry_frame_in[31:gtt_pkg::LIN_TBL_LO],
		lin_addr_in[gtt_pkg::LIN_TBL_HI:gtt_pkg::LIN_TBL_LO],
		2'h0}; // R9 R17
	assign page_term = {entry_frame_in[31:gtt_pkg::LIN_TBL_LO],
		lin_addr_in[gtt_pkg::LIN_OFF_HI:0]}; // R10
	// Large leaf keeps the table and offset fields (bits 21:0) of the linear address
	assign large_term = {entry_frame_in[31:gtt_pkg::LIN_DIR_LO],
		lin_addr_in[gtt_pkg::LIN_DIR_LO-1:0]}; // R9
	assign leaf_term = leaf_size_in ? large_term : page_term; // R9

	always_comb begin
		root_d = root_load_in ? root_value_in : root_q; // R13
		gpa_lo = 32'h0000_0000;
		gpa_use = 1'b0;
		if (root_load_in && ext_on) begin
			gpa_lo = root_value_in; // R14
			gpa_use = 1'b1;
		end else if (ctl_reload_in && ext_on) begin
			gpa_lo = root_q; // R16
			gpa_use = 1'b1;
		end else if (mem_access_in) begin // R12
			gpa_use = 1'b1;
			if (!flags_in.paging_enable_flag)
				gpa_lo = lin_addr_in; // R8
			else begin
				unique case (walk_level_in)
				2'h0: gpa_lo = dir_term; // R10
				2'h1: gpa_lo = tbl_term; // R9 R17
				2'h2: gpa_lo = page_term; // R10
				2'h3: gpa_lo = leaf_term; // R9
				endcase
			end
		end
	end
	// Guest addresses here are 32 bits; the upper part stays zero
	assign gpa = {{(gtt_pkg::GPA_W-32){1'b0}}, gpa_lo}; // R18

	// Request holds until the walker answers
	typedef enum logic {
		REQ_IDLE = 1'b0,
		REQ_WAIT = 1'b1
	} gtt_req_state_t;
	gtt_req_state_t            req_q;
	gtt_req_state_t            req_d;
	logic [gtt_pkg::GPA_W-1:0] gpa_q;
	logic [gtt_pkg::GPA_W-1:0] gpa_d;
	always_comb begin
		req_d = req_q;
		gpa_d = gpa_q;
		unique case (req_q)
		REQ_IDLE: begin
			// Refused accesses are dropped, never queued behind a walk
			if (gpa_use && sl_on) begin
				req_d = REQ_WAIT;
				gpa_d = gpa; // R18
			end
		end
		REQ_WAIT: begin
			if (sl_done_in)
				req_d = REQ_IDLE;
		end
		endcase
	end
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			req_q <= REQ_IDLE;
			gpa_q <= '0;
			root_q <= '0;
		end else begin
			req_q <= req_d;
			gpa_q <= gpa_d;
			root_q <= root_d;
		end
	end
	assign sl_req_out = (req_q == REQ_WAIT);
	assign sl_gpa_out = gpa_q;
	// Top entry: pointer bits 51:12, index 47:39, three low zeros
	assign sl_top_entry_out = {
		ctl_in.sl_root_pointer[gtt_pkg::PTR_HI:gtt_pkg::PTR_LO],
		gpa_q[gtt_pkg::TOP_IDX_HI:gtt_pkg::TOP_IDX_LO], 3'h0}; // R19

	// ----------------------------------------------------------------
	// Pointer-table entry fetch after an extension root load or control reload
	// ----------------------------------------------------------------
	typedef enum logic {
		PTR_IDLE  = 1'b0,
		PTR_FETCH = 1'b1
	} gtt_ptr_state_t;
	gtt_ptr_state_t ptr_q;
	gtt_ptr_state_t ptr_d;
	logic [1:0]     idx_q;
	logic [1:0]     idx_d;
	logic           ptr_start;
	logic           ptr_last;
	always_comb begin
		ptr_start = (root_load_in || ctl_reload_in) && ext_on; // R14 R16
		ptr_last = (idx_q == 2'(gtt_pkg::PTE_COUNT - 1));
		ptr_d = ptr_q;
		idx_d = idx_q;
		unique case (ptr_q)
		PTR_IDLE: begin
			if (ptr_start) begin
				ptr_d = PTR_FETCH;
				idx_d = gtt_pkg::PTR_IDX_RST;
			end
		end
		PTR_FETCH: begin
			// A load during a running fetch is not restarted
			idx_d = idx_q + 2'h1;
			if (ptr_last)
				ptr_d = PTR_IDLE; // R14
		end
		endcase
	end
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			ptr_q <= PTR_IDLE;
			idx_q <= gtt_pkg::PTR_IDX_RST;
		end else begin
			ptr_q <= ptr_d;
			idx_q <= idx_d;
		end
	end
	assign pte_fetch_out = (ptr_q == PTR_FETCH);
	assign pte_idx_out = idx_q;

	// ----------------------------------------------------------------
	// Privilege check on completion
	// ----------------------------------------------------------------
	// Only the answering cycle is judged; idle permissions are noise
	logic viol_d;
	logic viol_q;
	always_comb begin
		viol_d = (req_q == REQ_WAIT) && sl_done_in &&
			|(perm_in.wanted & ~perm_in.allowed); // R11
	end
	always_ff @(posedge core_clk_in) begin
		if (rst_in)
			viol_q <= 1'b0;
		else
			viol_q <= viol_d;
	end
	assign violation_out = viol_q;
	assign guest_exit_out = viol_q; // R11
endmodule

/* File: dv/gtt_walker_model.sv */
/* Behavioural second-level walker facing gtt_core's request port.
   Assumes the bench sets latency and denial between requests. */
`timescale 1ns/1ps
module gtt_walker_model (
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       req_in,
	input  wire logic       deny_in,
	input  wire logic [3:0] lat_in,
	output logic            done_out,
	output gtt_pkg::gtt_perm_t perm_out
);
	logic [3:0] cnt_q;
	// Perm inverts every cycle between answers, so a stale grant looks valid only on alternate cycles
	always_ff @(posedge clk_in) begin
		cnt_q <= (rst_in || !req_in || done_out) ? 4'h0 : cnt_q + 4'h1;
		done_out <= !rst_in && req_in && !done_out && cnt_q == lat_in;
		perm_out <= rst_in ? '0 : (cnt_q == lat_in) ?
			{deny_in ? 3'h0 : 3'h7, 3'h1} : ~perm_out;
	end
endmodule

/* File: dv/gtt_core_checker.sv */
/* Port-level assertions for gtt_core, bound to every instance.
   Assumes one core clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module gtt_core_checker (
	input wire logic                core_clk_in,
	input wire logic                rst_in,
	input wire gtt_pkg::gtt_ctl_t   ctl_in,
	input wire gtt_pkg::gtt_flags_t flags_in,
	input wire logic                root_load_in,
	input wire logic [31:0]         root_value_in,
	input wire logic                ctl_reload_in,
	input wire logic                mem_access_in,
	input wire logic                sl_done_in,
	input wire gtt_pkg::gtt_perm_t  perm_in,
	input wire logic [15:0]         cur_tag_out,
	input wire logic                sl_active_out,
	input wire logic                ext_paging_out,
	input wire logic                sl_req_out,
	input wire logic [47:0]         sl_gpa_out,
	input wire logic [51:0]         sl_top_entry_out,
	input wire logic                pte_fetch_out,
	input wire logic [1:0]          pte_idx_out,
	input wire logic                violation_out,
	input wire logic                guest_exit_out
);
	logic guest;
	logic deny;
	logic take;
	assign guest = ctl_in.mode == gtt_pkg::GTT_GUEST;
	assign deny = |(perm_in.wanted & ~perm_in.allowed);
	assign take = !sl_req_out && sl_active_out;
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	AST_TAG_ZERO: assert property (!(guest && ctl_in.tag_enable) |=>
		cur_tag_out == 16'h0000) else $error("tag not zero");
	AST_TAG_FIELD: assert property (guest && ctl_in.tag_enable |=>
		cur_tag_out == $past(ctl_in.tag_field)) else $error("tag field");
	AST_SL_GATE: assert property (sl_active_out == (guest &&
		ctl_in.sl_enable && ctl_in.primary_ctls[31])) else $error("gate");
	AST_EXT: assert property (ext_paging_out ==
		(flags_in.paging_enable_flag && flags_in.address_extension_flag
		&& !flags_in.long_mode_active_flag)) else $error("ext paging");
	AST_ROOT_LOCAL: assert property (take && root_load_in &&
		!ext_paging_out && !ctl_reload_in && !mem_access_in |=>
		!sl_req_out) else $error("root load translated");
	AST_ROOT_EXT: assert property (take && root_load_in && ext_paging_out
		|=> sl_req_out && pte_fetch_out && sl_gpa_out ==
		{16'h0000, $past(root_value_in)}) else $error("ext root load");
	AST_PTE_RUN: assert property ($rose(pte_fetch_out) |->
		(pte_idx_out == 2'h0) ##1 (pte_fetch_out && pte_idx_out == 2'h1)
		##1 (pte_fetch_out && pte_idx_out == 2'h2) ##1 (pte_fetch_out &&
		pte_idx_out == 2'h3) ##1 !pte_fetch_out) else $error("pte run");
	AST_VIOL: assert property (sl_req_out && sl_done_in |=>
		violation_out == $past(deny) && guest_exit_out == $past(deny))
		else $error("violation");
	AST_TOP: assert property (sl_top_entry_out ==
		{ctl_in.sl_root_pointer[51:12], sl_gpa_out[47:39], 3'h0})
		else $error("top entry");
	AST_HOLD: assert property (sl_req_out && !sl_done_in |=>
		sl_req_out && $stable(sl_gpa_out)) else $error("request hold");
endmodule
bind gtt_core gtt_core_checker chk (.*);

/* File: dv/gtt_core_tb.sv */
/* Self-checking bench for gtt_core with a behavioural walker.
   Assumes default ENTRIES and the bound port checker. */
`timescale 1ns/1ps
module gtt_core_tb;
	logic core_clk_in = 1'b0;
	logic rst_in = 1'b1;
	gtt_pkg::gtt_ctl_t ctl_in = '0;
	gtt_pkg::gtt_flags_t flags_in = '0;
	gtt_pkg::gtt_entry_tag_t [3:0] entries_in = '0;
	gtt_pkg::gtt_perm_t perm_in;
	logic [11:0] pctag_in = 12'h000;
	logic [31:0] root_value_in = '0, lin_addr_in = '0;
	logic [31:0] entry_frame_in = 32'h0078_9000;
	logic [1:0] walk_level_in = 2'h0, pte_idx_out;
	logic pct_on_in = 1'b0, root_load_in = 1'b0, ctl_reload_in = 1'b0;
	logic mem_access_in = 1'b0, leaf_size_in = 1'b0, mode_switch_in = 1'b0;
	logic deny = 1'b0, sl_done_in, sl_active_out, ext_paging_out;
	logic sl_req_out, pte_fetch_out, violation_out, guest_exit_out;
	logic flush_out;
	logic [3:0] lat = 4'h1, hit_out;
	logic [15:0] cur_tag_out;
	logic [47:0] sl_gpa_out;
	logic [51:0] sl_top_entry_out;
	int miscompares = 0, comparisons = 0;
	always #2.5 core_clk_in = ~core_clk_in;
	gtt_core dut (.*);
	gtt_walker_model walker (.clk_in(core_clk_in), .rst_in(rst_in),
		.req_in(sl_req_out), .deny_in(deny), .lat_in(lat),
		.done_out(sl_done_in), .perm_out(perm_in));
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// Kind 0 root load, 1 control reload, 2 memory access
	task automatic req(input int k, input logic [47:0] gpa,
		input logic viol, input int fetch);
		int n = 0;
		int f = 0;
		@(posedge core_clk_in);
		root_load_in <= (k == 0);
		ctl_reload_in <= (k == 1);
		mem_access_in <= (k == 2);
		@(posedge core_clk_in);
		{root_load_in, ctl_reload_in, mem_access_in} <= 3'h0;
		#1;
		check(sl_req_out, 1'b1);
		check(sl_gpa_out, gpa);
		check(sl_top_entry_out, {ctl_in.sl_root_pointer[51:12],
			gpa[47:39], 3'h0});
		while (sl_req_out === 1'b1 && n < 40) begin
			f += (pte_fetch_out === 1'b1);
			n++;
			@(posedge core_clk_in);
			#1;
		end
		check(f, fetch);
		check({violation_out, guest_exit_out}, {viol, viol});
	endtask
	task automatic test_tags();
		for (int i = 0; i < 4; i++) begin
			@(posedge core_clk_in);
			ctl_in.mode <= (i == 0) ? gtt_pkg::GTT_OUTSIDE :
				(i == 1) ? gtt_pkg::GTT_ROOT : gtt_pkg::GTT_GUEST;
			ctl_in.tag_enable <= (i != 2);
			repeat (2) @(posedge core_clk_in);
			#1;
			check(cur_tag_out, (i == 3) ? 16'h5A3C : 16'h0000);
		end
		for (int i = 0; i < 2; i++) begin
			@(posedge core_clk_in);
			ctl_in.tag_enable <= i[0];
			mode_switch_in <= 1'b1;
			@(posedge core_clk_in);
			mode_switch_in <= 1'b0;
			#1;
			check(flush_out, !i[0]);
		end
		$display("test_tags done");
	endtask
	task automatic test_hit();
		@(posedge core_clk_in);
		pctag_in <= 12'h0A5;
		entries_in[0] <= '{1'b1, 16'h5A3C, 12'h0A5};
		entries_in[1] <= '{1'b1, 16'h5A3C, 12'h0A4};
		entries_in[2] <= '{1'b1, 16'h5A3D, 12'h0A5};
		entries_in[3] <= '{1'b0, 16'h5A3C, 12'h0A5};
		for (int i = 0; i < 2; i++) begin
			@(posedge core_clk_in);
			pct_on_in <= i[0];
			@(posedge core_clk_in);
			#1;
			check(hit_out, i[0] ? 4'h1 : 4'h3);
		end
		$display("test_hit done");
	endtask
	task automatic test_gate();
		for (int i = 0; i < 8; i++) begin
			@(posedge core_clk_in);
			flags_in <= i[2:0];
			ctl_in.primary_ctls[31] <= i[1];
			ctl_in.sl_enable <= i[0];
			@(posedge core_clk_in);
			#1;
			check(ext_paging_out, i == 6);
			check(sl_active_out, i[1:0] == 2'h3);
		end
		$display("test_gate done");
	endtask
	task automatic test_ext();
		@(posedge core_clk_in);
		flags_in <= 3'h6;
		lat <= 4'h8;
		root_value_in <= 32'h0012_3020;
		req(0, 48'h0000_0012_3020, 1'b0, 4);
		req(1, 48'h0000_0012_3020, 1'b0, 4);
		$display("test_ext done");
	endtask
	task automatic test_local();
		@(posedge core_clk_in);
		{flags_in, lat, lin_addr_in} <= {3'h4, 4'h1, 32'hC040_1ABC};
		root_value_in <= 32'h0045_6000;
		root_load_in <= 1'b1;
		@(posedge core_clk_in);
		root_load_in <= 1'b0;
		#1;
		check(sl_req_out, 1'b0);
		for (int i = 0; i < 5; i++) begin
			@(posedge core_clk_in);
			walk_level_in <= (i > 3) ? 2'h3 : i[1:0];
			leaf_size_in <= (i == 4);
			req(2, (i == 0) ? 48'h0000_0045_6C04 : (i == 1) ?
				48'h0000_0078_9004 : (i == 4) ? 48'h0000_0040_1ABC :
				48'h0000_0078_9ABC, 1'b0, 0);
		end
		@(posedge core_clk_in);
		flags_in <= 3'h0;
		req(2, 48'h0000_C040_1ABC, 1'b0, 0);
		deny <= 1'b1;
		req(2, 48'h0000_C040_1ABC, 1'b1, 0);
		deny <= 1'b0;
		$display("test_local done");
	endtask
	initial begin
		ctl_in.tag_field = 16'h5A3C;
		ctl_in.sl_root_pointer = 64'h0000_000A_BCDE_F000;
		repeat (4) @(posedge core_clk_in);
		rst_in <= 1'b0;
		test_tags();
		test_hit();
		test_gate();
		test_ext();
		test_local();
		finish_test();
	end
	// Run needs about a hundred cycles; this cuts a hang short
	initial begin
		repeat (3000) @(posedge core_clk_in);
		miscompares++;
		finish_test();
	end
endmodule
